// >>> rtl/scp_map.svh
// Register offsets, field positions, reset values and timing counts of the clock select block.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define SCP_OFS_SYS_SEL      8'h00
`define SCP_OFS_PRESCALE     8'h04
`define SCP_OFS_FREEZE       8'h08
`define SCP_OFS_RTC_CTRL     8'h0c
`define SCP_OFS_USB_CTRL     8'h10
`define SCP_OFS_STATUS       8'h14

// Field positions.
`define SCP_SYS_SEL_MSB      2
`define SCP_SYS_SEL_LSB      0
`define SCP_PSA_MSB          6
`define SCP_PSA_LSB          2
`define SCP_PSBC_MSB         1
`define SCP_PSBC_LSB         0
`define SCP_FREEZE_BIT       0
`define SCP_RTC_SRC_MSB      3
`define SCP_RTC_SRC_LSB      1
`define SCP_RTC_EN_BIT       0
`define SCP_USB_DIV_MSB      5
`define SCP_USB_DIV_LSB      3
`define SCP_USB_SRC_MSB      2
`define SCP_USB_SRC_LSB      1
`define SCP_USB_EN_BIT       0
`define SCP_STAT_SW_BIT      3

// Reset values.
`define SCP_RST_SYS_SEL      3'h0
`define SCP_RST_PSA          5'h00
`define SCP_RST_PSBC         2'h0
`define SCP_RST_RTC_SRC      3'h0
`define SCP_RST_USB_DIV      3'h0
`define SCP_RST_USB_SRC      2'h0

// Field limits and codes.
`define SCP_SYS_SEL_MAX      3'h4
`define SCP_PSA_MAX          5'h11
`define SCP_USB_DIV_MAX      3'h5
`define SCP_USB_SRC_MAX      2'h1
`define SCP_RTC_RSV_A        3'h3
`define SCP_RTC_RSV_B        3'h4
`define SCP_PSBC_B4          2'h2
`define SCP_PSBC_B2          2'h3

// Source clock cycles spent on each side of a system clock switch.
`define SCP_SWITCH_CYCLES    2

// AXI response codes.
`define SCP_RESP_OKAY        2'h0
`define SCP_RESP_SLVERR      2'h2

`endif

// >>> rtl/scp_pkg.sv
// Types shared by the clock select and prescaler block.
package scp_pkg;

  typedef enum logic [1:0]
  {
    SCP_SW_IDLE = 2'b00,
    SCP_SW_OLD  = 2'b01,
    SCP_SW_NEW  = 2'b10
  } scp_switch_state_t;

endpackage

// >>> rtl/scp_system_clock_select_prescale.sv
// System clock selection, prescalers, RTC and USB clock control with AXI4-Lite registers.
// Function
// R1 - System clock source chosen by 3-bit code, 000 to 100; 101-111 reserved.
// R2 - Source switch takes two outgoing cycles then two incoming cycles.
// R3 - Select write refused while the requested source is not stable.
// R4 - Outgoing source kept enabled until the switch has completed.
// R5 - Select and prescaler registers written only under configuration change protection.
// R6 - Prescaler A divides by 1 to 512 from a 5-bit code.
// R7 - Prescaler A changeable at run time, setting the x4 peripheral clock.
// R8 - 2-bit code sets prescaler B and C divisors.
// R9 - B makes x2 clock from x4; C makes base and CPU clocks.
// R10 - Freeze bit blocks further select and prescaler changes until reset.
// R11 - Freeze bit clears only on reset; set only under protection.
// R12 - 3-bit code selects RTC clock source; 011 and 100 reserved.
// R13 - RTC enable passes the selected source; clear withholds it.
// R14 - 3-bit code divides the USB clock by 1 to 32.
// R15 - USB divide field ignored while USB source enable is set.
// R16 - 2-bit code selects USB source: PLL or 32MHz oscillator.
// R17 - Software calibrates 32MHz oscillator to 48MHz before using it for USB.
// R18 - USB enable delivers the selected, divided source to the USB module.
// R19 - Software writes zero to every reserved bit.
// R20 - Prescaler changes stay glitch free, applied at slowest clock edge.
// R21 - Disabled oscillator cannot be selected; active oscillator cannot be disabled.
// R22 - Reserved codes in any field are ignored, keeping the old value.
// R23 - After reset select is 000 and prescalers give no division.
`timescale 1ns/1ps
`include "scp_map.svh"

module scp_system_clock_select_prescale
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite write address channel.
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output      logic        s_axi_awready_o,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output      logic        s_axi_wready_o,
  // AXI4-Lite write response channel.
  output      logic [1:0]  s_axi_bresp_o,
  output      logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read address channel.
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output      logic        s_axi_arready_o,
  // AXI4-Lite read data channel.
  output      logic [31:0] s_axi_rdata_o,
  output      logic [1:0]  s_axi_rresp_o,
  output      logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Configuration change protection window.
  input  wire logic        ccp_unlock_i,
  // Oscillator status and source ticks, indexed by system select code.
  input  wire logic [4:0]  osc_enabled_i,
  input  wire logic [4:0]  osc_ready_i,
  input  wire logic [4:0]  osc_tick_i,
  // RTC and USB source ticks, indexed by their select codes.
  input  wire logic [7:0]  rtc_src_tick_i,
  input  wire logic [1:0]  usb_src_tick_i,
  // Oscillators that must stay enabled.
  output      logic [4:0]  osc_hold_on_o,
  // Clock selection state.
  output      logic [2:0]  sys_src_active_o,
  output      logic        sys_switching_o,
  // Derived clock ticks.
  output      logic        system_clk_o,
  output      logic        periph_clk_x4_o,
  output      logic        periph_clk_x2_o,
  output      logic        periph_clk_base_o,
  output      logic        cpu_clk_o,
  output      logic        rtc_clk_o,
  output      logic        usb_clk_o
);

  // Register address decode, shared by writes and reads.
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // Prescaler A code check.
  function automatic logic psa_valid(input logic [4:0] code);
    psa_valid = (code == 5'h00) || (code[0] && (code <= `SCP_PSA_MAX));
  endfunction

  // Prescaler A code to power of two.
  function automatic logic [3:0] psa_log2(input logic [4:0] code);
    logic [5:0] t;
    t = ({1'b0, code} + 6'h01) >> 1;
    psa_log2 = (code == 5'h00) ? 4'h0 : t[3:0];
  endfunction

  // Software-visible settings.
  logic [2:0]  sys_sel;
  logic [4:0]  psa;
  logic [1:0]  psbc;
  logic        freeze;
  logic [2:0]  rtc_sel;
  logic        rtc_en;
  logic [2:0]  usb_div;
  logic [1:0]  usb_sel;
  logic        usb_en;

  // Switch and prescaler state.
  scp_pkg::scp_switch_state_t sw_state;
  logic [2:0]  act_sel;
  logic        sw_cnt;
  logic [4:0]  psa_act;
  logic [1:0]  psbc_act;
  logic [8:0]  cnt_a;
  logic [1:0]  cnt_b;
  logic        cnt_c;
  logic [4:0]  usb_cnt;

  // Bus state.
  logic        aw_got;
  logic        w_got;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        do_wr;
  logic        wr_map;

  // Combinational decode.
  logic [8:0]  mask_a;
  logic [9:0]  mask_a_w;
  logic [1:0]  mask_b;
  logic        mask_c;
  logic        sys_tick;
  logic        x4_tick;
  logic        x2_tick;
  logic        base_tick;
  logic [5:0]  usb_mask_w;
  logic [4:0]  usb_mask;
  logic        usb_tick;
  logic        prot_ok;
  logic [2:0]  w_sys;
  logic [4:0]  w_psa;
  logic [1:0]  w_psbc;
  logic [2:0]  w_rtc;
  logic [2:0]  w_udiv;
  logic [1:0]  w_usrc;
  logic [31:0] next_rdata;
  logic        next_rmap;

  assign do_wr   = aw_got && w_got && !s_axi_bvalid_o;
  assign prot_ok = ccp_unlock_i && !freeze;                   // [R5] [R10]
  assign w_sys   = wdata_q[`SCP_SYS_SEL_MSB:`SCP_SYS_SEL_LSB];
  assign w_psa   = wdata_q[`SCP_PSA_MSB:`SCP_PSA_LSB];
  assign w_psbc  = wdata_q[`SCP_PSBC_MSB:`SCP_PSBC_LSB];
  assign w_rtc   = wdata_q[`SCP_RTC_SRC_MSB:`SCP_RTC_SRC_LSB];
  assign w_udiv  = wdata_q[`SCP_USB_DIV_MSB:`SCP_USB_DIV_LSB];
  assign w_usrc  = wdata_q[`SCP_USB_SRC_MSB:`SCP_USB_SRC_LSB];
  assign wr_map  = hit(awaddr_q, `SCP_OFS_SYS_SEL) || hit(awaddr_q, `SCP_OFS_PRESCALE)
                || hit(awaddr_q, `SCP_OFS_FREEZE) || hit(awaddr_q, `SCP_OFS_RTC_CTRL)
                || hit(awaddr_q, `SCP_OFS_USB_CTRL) || hit(awaddr_q, `SCP_OFS_STATUS);

  // The system clock pauses while a switch is in progress.
  assign sys_tick = (sw_state == scp_pkg::SCP_SW_IDLE) && osc_tick_i[act_sel];

  always_comb
  begin
    mask_a_w = (10'h001 << psa_log2(psa_act)) - 10'h001;      // [R6]
    mask_a   = mask_a_w[8:0];
    case (psbc_act)                                           // [R8]
      `SCP_PSBC_B4: mask_b = 2'h3;
      `SCP_PSBC_B2: mask_b = 2'h1;
      default:      mask_b = 2'h0;
    endcase
    mask_c = psbc_act[0];
  end

  // Chained ticks keep the x4, x2, base and CPU clocks aligned to the system clock.
  assign x4_tick   = sys_tick && (cnt_a == mask_a);           // [R7]
  assign x2_tick   = x4_tick && (cnt_b == mask_b);            // [R9]
  assign base_tick = x2_tick && (cnt_c == mask_c);            // [R9]

  assign usb_mask_w = (6'h01 << usb_div) - 6'h01;             // [R14]
  assign usb_mask   = usb_mask_w[4:0];
  assign usb_tick   = usb_src_tick_i[usb_sel[0]] && (usb_cnt == usb_mask);

  // AXI write address and data capture, either order.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else if (do_wr)
    begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got   <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got    <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb0_q <= s_axi_wstrb_i[0];
      end
    end
  end

  assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_got && !s_axi_bvalid_o;

  // AXI write response.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `SCP_RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_map ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // System clock select register and switch request.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sys_sel <= `SCP_RST_SYS_SEL;                            // [R23]
    end
    else if (do_wr && wstrb0_q && hit(awaddr_q, `SCP_OFS_SYS_SEL) && prot_ok
             && (sw_state == scp_pkg::SCP_SW_IDLE)
             && (w_sys <= `SCP_SYS_SEL_MAX)                   // [R1] [R22]
             && osc_enabled_i[w_sys] && osc_ready_i[w_sys])   // [R3] [R21]
    begin
      sys_sel <= w_sys;
    end
  end

  // Switch sequencer: two ticks of the old source, then two of the new.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_state <= scp_pkg::SCP_SW_IDLE;
      sw_cnt   <= 1'b0;
      act_sel  <= `SCP_RST_SYS_SEL;
    end
    else
    begin
      case (sw_state)
        scp_pkg::SCP_SW_IDLE:
        begin
          sw_cnt <= 1'b0;
          if (sys_sel != act_sel)
          begin
            sw_state <= scp_pkg::SCP_SW_OLD;
          end
        end
        scp_pkg::SCP_SW_OLD:
        begin
          if (osc_tick_i[act_sel])                            // [R2]
          begin
            sw_cnt <= !sw_cnt;
            if (sw_cnt)
            begin
              sw_state <= scp_pkg::SCP_SW_NEW;
            end
          end
        end
        scp_pkg::SCP_SW_NEW:
        begin
          if (osc_tick_i[sys_sel])                            // [R2]
          begin
            sw_cnt <= !sw_cnt;
            if (sw_cnt)
            begin
              sw_state <= scp_pkg::SCP_SW_IDLE;
              act_sel  <= sys_sel;
            end
          end
        end
        default:
        begin
          sw_state <= scp_pkg::SCP_SW_IDLE;
          sw_cnt   <= 1'b0;
        end
      endcase
    end
  end

  // Oscillators that may not be disabled: the running one and, mid switch, the target.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      osc_hold_on_o <= 5'h01;
    end
    else
    begin
      osc_hold_on_o <= (5'h01 << act_sel) | (5'h01 << sys_sel);  // [R4] [R21]
    end
  end

  // Prescaler control register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      psa  <= `SCP_RST_PSA;                                   // [R23]
      psbc <= `SCP_RST_PSBC;
    end
    else if (do_wr && wstrb0_q && hit(awaddr_q, `SCP_OFS_PRESCALE) && prot_ok)  // [R5] [R10]
    begin
      if (psa_valid(w_psa))                                   // [R22]
      begin
        psa <= w_psa;
      end
      psbc <= w_psbc;
    end
  end

  // Freeze bit, cleared only by reset.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      freeze <= 1'b0;                                         // [R11]
    end
    else if (do_wr && wstrb0_q && hit(awaddr_q, `SCP_OFS_FREEZE) && ccp_unlock_i
             && wdata_q[`SCP_FREEZE_BIT])
    begin
      freeze <= 1'b1;                                         // [R10] [R11]
    end
  end

  // Prescaler counters; new settings load on a base clock edge.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_a    <= 9'h000;
      cnt_b    <= 2'h0;
      cnt_c    <= 1'b0;
      psa_act  <= `SCP_RST_PSA;
      psbc_act <= `SCP_RST_PSBC;
    end
    else
    begin
      if (sys_tick)
      begin
        cnt_a <= x4_tick ? 9'h000 : cnt_a + 9'h001;
      end
      if (x4_tick)
      begin
        cnt_b <= x2_tick ? 2'h0 : cnt_b + 2'h1;
      end
      if (x2_tick)
      begin
        cnt_c <= base_tick ? 1'b0 : !cnt_c;
      end
      if (base_tick)
      begin
        psa_act  <= psa;                                      // [R20]
        psbc_act <= psbc;                                     // [R20]
      end
    end
  end

  // Derived clock tick outputs.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      system_clk_o      <= 1'b0;
      periph_clk_x4_o   <= 1'b0;
      periph_clk_x2_o   <= 1'b0;
      periph_clk_base_o <= 1'b0;
      cpu_clk_o         <= 1'b0;
      sys_src_active_o  <= `SCP_RST_SYS_SEL;
      sys_switching_o   <= 1'b0;
    end
    else
    begin
      system_clk_o      <= sys_tick;
      periph_clk_x4_o   <= x4_tick;                           // [R7]
      periph_clk_x2_o   <= x2_tick;                           // [R9]
      periph_clk_base_o <= base_tick;                         // [R9]
      cpu_clk_o         <= base_tick;                         // [R9]
      sys_src_active_o  <= act_sel;
      sys_switching_o   <= (sw_state != scp_pkg::SCP_SW_IDLE);
    end
  end

  // RTC clock control register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rtc_sel <= `SCP_RST_RTC_SRC;
      rtc_en  <= 1'b0;
    end
    else if (do_wr && wstrb0_q && hit(awaddr_q, `SCP_OFS_RTC_CTRL))
    begin
      if ((w_rtc != `SCP_RTC_RSV_A) && (w_rtc != `SCP_RTC_RSV_B))  // [R12] [R22]
      begin
        rtc_sel <= w_rtc;
      end
      rtc_en <= wdata_q[`SCP_RTC_EN_BIT];
    end
  end

  // RTC clock gate.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rtc_clk_o <= 1'b0;
    end
    else
    begin
      rtc_clk_o <= rtc_en && rtc_src_tick_i[rtc_sel];         // [R13]
    end
  end

  // USB clock control register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      usb_div <= `SCP_RST_USB_DIV;
      usb_sel <= `SCP_RST_USB_SRC;
      usb_en  <= 1'b0;
    end
    else if (do_wr && wstrb0_q && hit(awaddr_q, `SCP_OFS_USB_CTRL))
    begin
      if (!usb_en && (w_udiv <= `SCP_USB_DIV_MAX))            // [R15] [R22]
      begin
        usb_div <= w_udiv;
      end
      if (w_usrc <= `SCP_USB_SRC_MAX)                         // [R16] [R22]
      begin
        usb_sel <= w_usrc;
      end
      usb_en <= wdata_q[`SCP_USB_EN_BIT];
    end
  end

  // USB divider and gate.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      usb_cnt   <= 5'h00;
      usb_clk_o <= 1'b0;
    end
    else
    begin
      if (!usb_en)
      begin
        usb_cnt <= 5'h00;
      end
      else if (usb_src_tick_i[usb_sel[0]])
      begin
        usb_cnt <= usb_tick ? 5'h00 : usb_cnt + 5'h01;       // [R14]
      end
      usb_clk_o <= usb_en && usb_tick;                        // [R18]
    end
  end

  // Read data mux.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rmap  = 1'b1;
    if (hit(s_axi_araddr_i, `SCP_OFS_SYS_SEL))
    begin
      next_rdata[`SCP_SYS_SEL_MSB:`SCP_SYS_SEL_LSB] = sys_sel;
    end
    else if (hit(s_axi_araddr_i, `SCP_OFS_PRESCALE))
    begin
      next_rdata[`SCP_PSA_MSB:`SCP_PSA_LSB]   = psa;
      next_rdata[`SCP_PSBC_MSB:`SCP_PSBC_LSB] = psbc;
    end
    else if (hit(s_axi_araddr_i, `SCP_OFS_FREEZE))
    begin
      next_rdata[`SCP_FREEZE_BIT] = freeze;
    end
    else if (hit(s_axi_araddr_i, `SCP_OFS_RTC_CTRL))
    begin
      next_rdata[`SCP_RTC_SRC_MSB:`SCP_RTC_SRC_LSB] = rtc_sel;
      next_rdata[`SCP_RTC_EN_BIT]                   = rtc_en;
    end
    else if (hit(s_axi_araddr_i, `SCP_OFS_USB_CTRL))
    begin
      next_rdata[`SCP_USB_DIV_MSB:`SCP_USB_DIV_LSB] = usb_div;
      next_rdata[`SCP_USB_SRC_MSB:`SCP_USB_SRC_LSB] = usb_sel;
      next_rdata[`SCP_USB_EN_BIT]                   = usb_en;
    end
    else if (hit(s_axi_araddr_i, `SCP_OFS_STATUS))
    begin
      next_rdata[`SCP_SYS_SEL_MSB:`SCP_SYS_SEL_LSB] = act_sel;
      next_rdata[`SCP_STAT_SW_BIT] = (sw_state != scp_pkg::SCP_SW_IDLE);
    end
    else
    begin
      next_rmap = 1'b0;
    end
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  // AXI read response.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `SCP_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= next_rmap ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule // scp_system_clock_select_prescale

// >>> sim/scp_asserts.sv
// Concurrent checks on the clock select and prescaler outputs.
`timescale 1ns/1ps
module scp_asserts
(
  // Clock and reset.
  input logic       clk_i,
  input logic       rst_n_i,
  // Selection state.
  input logic [4:0] osc_hold_on_o,
  input logic [2:0] sys_src_active_o,
  input logic       sys_switching_o,
  // Derived clock ticks.
  input logic       system_clk_o,
  input logic       periph_clk_x4_o,
  input logic       periph_clk_x2_o,
  input logic       periph_clk_base_o,
  input logic       cpu_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sel_legal_a: assert property (sys_src_active_o <= 3'h4)
    else $error("active source out of range");
  active_cause_a: assert property (
    $changed(sys_src_active_o) |-> $past(sys_switching_o))
    else $error("source changed outside a switch");
  switch_span_a: assert property (
    $rose(sys_switching_o) |-> sys_switching_o[*4])
    else $error("switch too short");
  switch_gate_a: assert property (
    sys_switching_o && $past(sys_switching_o) |-> !system_clk_o)
    else $error("system tick during switch");
  old_held_a: assert property (osc_hold_on_o[sys_src_active_o])
    else $error("active source not held on");
  cpu_base_a: assert property (cpu_clk_o == periph_clk_base_o)
    else $error("cpu and base ticks differ");
  x2_in_x4_a: assert property (periph_clk_x2_o |-> periph_clk_x4_o)
    else $error("x2 tick without x4 tick");
  base_phase_a: assert property (periph_clk_base_o |-> periph_clk_x2_o)
    else $error("base tick without x2 tick");
  x4_in_sys_a: assert property (periph_clk_x4_o |-> system_clk_o)
    else $error("x4 tick without system tick");
endmodule // scp_asserts

// >>> sim/tb_scp_system_clock_select_prescale.sv
// Self-checking testbench of the clock select and prescaler block.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module tb_scp_system_clock_select_prescale;
  logic clk_i = 0, rst_n_i = 0, ccp_unlock_i = 1, rnd = 0;
  logic [31:0] s_axi_awaddr_i = 0, s_axi_wdata_i = 0, s_axi_araddr_i = 0, d, es;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 1;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 1;
  logic [4:0] osc_enabled_i = 5'h1f, osc_ready_i = 5'h1f, osc_tick_i = 5'h1f;
  logic [7:0] rtc_src_tick_i = 0;
  logic [1:0] usb_src_tick_i = 0, lr, lb;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire s_axi_rvalid_o, sys_switching_o, system_clk_o, periph_clk_x4_o;
  wire periph_clk_x2_o, periph_clk_base_o, cpu_clk_o, rtc_clk_o, usb_clk_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [4:0] osc_hold_on_o;
  wire [2:0] sys_src_active_o;
  wire [6:0] clks = {usb_clk_o, rtc_clk_o, cpu_clk_o, periph_clk_base_o,
                     periph_clk_x2_o, periph_clk_x4_o, system_clk_o};
  int failures = 0, tests_run = 0, p, k;

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) osc_tick_i <= rnd ? 5'($urandom) : 5'h1f;

  scp_system_clock_select_prescale dut_u (.*);

  function automatic int adiv(input int c);
    return 1 << ((c + 1) / 2);
  endfunction
  function automatic int bdiv(input int b);
    return b == 2 ? 4 : (b == 3 ? 2 : 1);
  endfunction

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      failures++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    s_axi_awaddr_i <= 32'(a);
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
      n++;
    end while (s_axi_bvalid_o !== 1'b1 && n < 99);
    tmo(s_axi_bvalid_o);
    lb = s_axi_bresp_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    int n;
    s_axi_araddr_i <= 32'(a);
    s_axi_arvalid_i <= 1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
      n++;
    end while (s_axi_rvalid_o !== 1'b1 && n < 99);
    tmo(s_axi_rvalid_o);
    lr = s_axi_rresp_o;
    `CHK(s_axi_rdata_o, e)
  endtask
  task automatic per(input int i);
    int n, t;
    t = -1;
    p = 0;
    for (n = 0; n < 6000 && p == 0; n++)
    begin
      @(posedge clk_i);
      if (clks[i] === 1'b1)
      begin
        if (t >= 0) p = n - t;
        t = n;
      end
    end
    tmo(p != 0);
  endtask
  task automatic cnt(input int i);
    k = 0;
    repeat (3) @(posedge clk_i);
    repeat (8)
    begin
      @(posedge clk_i);
      k += int'(clks[i] === 1'b1);
    end
  endtask

  initial
  begin
    void'($urandom(84371));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    rchk(8'h00, 0);
    rchk(8'h04, 0);
    rchk(8'h08, 0);
    rchk(8'h18, 0);
    `CHK(lr, 2'h2)
    wr(8'h18, 0);
    `CHK(lb, 2'h2)
    $display("reset done");
    for (int c = 0; c < 18; c += (c == 0) ? 1 : 2)
    begin
      wr(8'h04, 32'(c << 2));
      rchk(8'h04, 32'(c << 2));
      per(1);
      per(1);
      `CHK(p, adiv(c))
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h04, 32'(b));
      per(2);
      per(2);
      `CHK(p, bdiv(b))
      per(3);
      `CHK(p, bdiv(b) * (b % 2 + 1))
      per(4);
      `CHK(p, bdiv(b) * (b % 2 + 1))
    end
    wr(8'h04, 32'h55);
    rchk(8'h04, 32'h01);
    ccp_unlock_i <= 0;
    wr(8'h04, 32'h07);
    rchk(8'h04, 32'h01);
    ccp_unlock_i <= 1;
    $display("prescale done");
    es = 0;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h0c, 32'(c * 2 + 1));
      if (c != 3 && c != 4) es = c;
      rchk(8'h0c, es * 2 + 1);
      rtc_src_tick_i <= 8'h01 << es;
      cnt(5);
      `CHK(k, 8)
    end
    wr(8'h0c, es * 2);
    `CHK(lb, 2'h0)
    cnt(5);
    `CHK(k, 0)
    $display("rtc done");
    for (int v = 0; v < 6; v++)
    begin
      wr(8'h10, 32'(v * 8 + (v % 2) * 2));
      wr(8'h10, 32'(v * 8 + (v % 2) * 2 + 1));
      usb_src_tick_i <= 2'(1 << (v % 2));
      per(6);
      per(6);
      `CHK(p, 1 << v)
    end
    wr(8'h10, 32'h03);
    rchk(8'h10, 32'h2b);
    wr(8'h10, 32'h00);
    wr(8'h10, 32'h30);
    rchk(8'h10, 32'h28);
    cnt(6);
    `CHK(k, 0)
    $display("usb done");
    rnd <= 1;
    es = 0;
    for (int i = 0; i < 16; i++)
    begin
      k = $urandom % 8;
      d = i % 2 ? 31 : $urandom | $urandom;
      p = i % 2 ? 31 : $urandom | $urandom;
      osc_enabled_i <= d[4:0];
      osc_ready_i <= 5'(p);
      wr(8'h00, 32'(k));
      if (k <= 4 && d[k] && p[k]) es = k;
      repeat (2) @(posedge clk_i);
      for (int n = 0; n < 300 && sys_switching_o !== 1'b0; n++) @(posedge clk_i);
      tmo(sys_switching_o === 1'b0);
      `CHK(sys_src_active_o, es[2:0])
      rchk(8'h14, es);
    end
    osc_enabled_i <= 5'h1f;
    osc_ready_i <= 5'h1f;
    $display("select done");
    ccp_unlock_i <= 0;
    wr(8'h08, 32'h1);
    rchk(8'h08, 0);
    ccp_unlock_i <= 1;
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h04);
    rchk(8'h04, 32'h01);
    wr(8'h00, (es == 1) ? 2 : 1);
    repeat (30) @(posedge clk_i);
    `CHK(sys_src_active_o, es[2:0])
    wr(8'h08, 32'h0);
    rchk(8'h08, 32'h1);
    rst_n_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    rchk(8'h08, 0);
    rchk(8'h00, 0);
    $display("freeze done");
    end_of_test;
  end
endmodule // tb_scp_system_clock_select_prescale

bind scp_system_clock_select_prescale scp_asserts chk_u (.*);
